// *** logic/asbp_host.sv ***
// Host controller sequencing the async SRAM byte port pins
`timescale 1ns/1ps
module asbp_host
   import asbp_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   reset,
   input  wire logic                   clkEn,
   input  wire logic                   reqValid,
   input  wire asbp_req_t              req,
   output logic                        reqReady,
   output logic                        rdValid,
   output logic      [ASBP_DATA_W-1:0] rdData,
   output logic                        chipSelN,
   output logic                        outEnN,
   output logic                        writeEnN,
   output logic      [ASBP_ADDR_W-1:0] wordAddress,
   output logic      [ASBP_DATA_W-1:0] byteDataOut,
   output logic                        byteDataOe,
   input  wire logic [ASBP_DATA_W-1:0] byteDataIn
);
   asbp_state_t            state_q;
   asbp_state_t            state_d;
   logic [ASBP_CNT_W-1:0]  cnt_q;
   logic [ASBP_CNT_W-1:0]  cnt_d;
   asbp_req_t              cur_q;
   asbp_req_t              cur_d;
   asbp_pins_t             pins_q;
   asbp_pins_t             pins_d;
   logic                   ready_q;
   logic                   ready_d;
   logic                   rdValid_q;
   logic                   rdValid_d;
   logic [ASBP_DATA_W-1:0] rdData_q;
   logic [ASBP_DATA_W-1:0] rdData_d;
   logic [ASBP_DATA_W-1:0] dataSync;
   logic                   take;

   asbp_sync u_sync (
      .clk   (clk),
      .clkEn (clkEn),
      .din   (byteDataIn),
      .dout  (dataSync)
   );

   function automatic asbp_pins_t idle_pins(input asbp_pins_t p);
      asbp_pins_t r;
      r            = p;
      r.chipSelN   = 1'b1;
      r.outEnN     = 1'b1;
      r.writeEnN   = 1'b1;
      r.byteDataOe = 1'b0;
      return r;
   endfunction

   // Countdown helpers, a zero count also ends the wait
   function automatic logic cnt_done(input logic [ASBP_CNT_W-1:0] c);
      return (c <= ASBP_CNT_ONE);
   endfunction

   function automatic logic [ASBP_CNT_W-1:0] cnt_dec(input logic [ASBP_CNT_W-1:0] c);
      return c - ASBP_CNT_ONE;
   endfunction

   // Request taken on this enabled edge
   assign take = (state_q == ASBP_IDLE) && reqValid && ready_q;

   // Pin sequencer
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      cur_d   = cur_q;
      pins_d  = pins_q;
      case (state_q)
         ASBP_IDLE: begin
            pins_d = idle_pins(pins_q);
            if (take) begin
               cur_d              = req;
               pins_d.wordAddress = req.addr;
               pins_d.outEnN      = 1'b1;
               pins_d.writeEnN    = 1'b1;
               pins_d.byteDataOut = req.wdata;
               state_d            = ASBP_SETUP;
            end
         end
         ASBP_SETUP: begin
            pins_d.chipSelN = 1'b0;
            if (cur_q.write) begin
               pins_d.writeEnN   = 1'b0;
               pins_d.outEnN     = 1'b1;
               pins_d.byteDataOe = 1'b1;
               cnt_d             = ASBP_WR_CNT;
               state_d           = ASBP_WRITE;
            end else begin
               pins_d.writeEnN = 1'b1;
               pins_d.outEnN   = 1'b0;
               cnt_d           = ASBP_RD_CNT + ASBP_SYNC_CNT;
               state_d         = ASBP_READ;
            end
         end
         ASBP_READ: begin
            if (cnt_done(cnt_q)) begin
               pins_d  = idle_pins(pins_q);
               cnt_d   = ASBP_HZ_CNT;
               state_d = ASBP_RECOV;
            end else begin
               cnt_d = cnt_dec(cnt_q);
            end
         end
         ASBP_WRITE: begin
            if (cnt_done(cnt_q)) begin
               pins_d.writeEnN = 1'b1;
               pins_d.chipSelN = 1'b1;
               cnt_d           = ASBP_HZ_CNT;
               state_d         = ASBP_RECOV;
            end else begin
               cnt_d = cnt_dec(cnt_q);
            end
         end
         ASBP_RECOV: begin
            pins_d.byteDataOe = 1'b0;
            if (cnt_done(cnt_q)) begin
               state_d = ASBP_IDLE;
            end else begin
               cnt_d = cnt_dec(cnt_q);
            end
         end
         default: begin
            state_d = ASBP_IDLE;
            pins_d  = idle_pins(pins_q);
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= ASBP_IDLE;
         cnt_q   <= ASBP_CNT_ZERO;
         cur_q   <= '0;
         pins_q  <= '{chipSelN: 1'b1, outEnN: 1'b1, writeEnN: 1'b1,
                      wordAddress: '0, byteDataOut: '0, byteDataOe: 1'b0};
      end else if (clkEn) begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         cur_q   <= cur_d;
         pins_q  <= pins_d;
      end
   end

   // Request handshake
   always_comb begin
      ready_d = ready_q;
      case (state_q)
         ASBP_IDLE: begin
            ready_d = !take;
         end
         ASBP_RECOV: begin
            if (cnt_done(cnt_q)) begin
               ready_d = 1'b1;
            end
         end
         default: begin
            ready_d = ready_q;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ready_q <= 1'b0;
      end else if (clkEn) begin
         ready_q <= ready_d;
      end
   end

   // Read return, one-cycle valid pulse
   always_comb begin
      rdValid_d = 1'b0;
      rdData_d  = rdData_q;
      if (state_q == ASBP_READ && cnt_done(cnt_q)) begin
         rdData_d  = dataSync;
         rdValid_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rdValid_q <= 1'b0;
         rdData_q  <= '0;
      end else if (clkEn) begin
         rdValid_q <= rdValid_d;
         rdData_q  <= rdData_d;
      end
   end

   // Outputs straight from registers
   assign reqReady    = ready_q;
   assign rdValid     = rdValid_q;
   assign rdData      = rdData_q;
   assign chipSelN    = pins_q.chipSelN;
   assign outEnN      = pins_q.outEnN;
   assign writeEnN    = pins_q.writeEnN;
   assign wordAddress = pins_q.wordAddress;
   assign byteDataOut = pins_q.byteDataOut;
   assign byteDataOe  = pins_q.byteDataOe;
endmodule // asbp_host

// *** logic/asbp_pkg.sv ***
// Package for the async SRAM byte port host controller
package asbp_pkg;
   localparam int ASBP_ADDR_W = 19;
   localparam int ASBP_DATA_W = 8;
   localparam int ASBP_CLK_PS = 25000;
   // Pin timing in picoseconds, slowest grade
   localparam int ASBP_T_RC_PS   = 15000;
   localparam int ASBP_T_AA_PS   = 15000;
   localparam int ASBP_T_PWE_PS  = 10000;
   localparam int ASBP_T_AW_PS   = 10000;
   localparam int ASBP_T_SD_PS   = 7000;
   localparam int ASBP_T_HZWE_PS = 7000;
   localparam int ASBP_T_HZ_PS   = 6000;
   function automatic int asbp_min_cyc(input int ps);
      int c;
      c = (ps + ASBP_CLK_PS - 1) / ASBP_CLK_PS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int ASBP_RD_CYC = asbp_min_cyc(ASBP_T_AA_PS);
   localparam int ASBP_WR_CYC = asbp_min_cyc(ASBP_T_PWE_PS);
   localparam int ASBP_HZ_CYC = asbp_min_cyc(ASBP_T_HZ_PS);
   localparam int ASBP_CNT_W = 4;
   localparam logic [ASBP_CNT_W-1:0] ASBP_RD_CNT = ASBP_CNT_W'(ASBP_RD_CYC);
   localparam logic [ASBP_CNT_W-1:0] ASBP_WR_CNT = ASBP_CNT_W'(ASBP_WR_CYC);
   localparam logic [ASBP_CNT_W-1:0] ASBP_HZ_CNT = ASBP_CNT_W'(ASBP_HZ_CYC);
   localparam logic [ASBP_CNT_W-1:0] ASBP_CNT_ZERO = 4'h0;
   localparam logic [ASBP_CNT_W-1:0] ASBP_CNT_ONE  = 4'h1;
   // Extra read wait for the two-flop input synchroniser
   localparam logic [ASBP_CNT_W-1:0] ASBP_SYNC_CNT = 4'h2;

   typedef struct packed {
      logic                   write;
      logic [ASBP_ADDR_W-1:0] addr;
      logic [ASBP_DATA_W-1:0] wdata;
   } asbp_req_t;

   typedef struct packed {
      logic                   chipSelN;
      logic                   outEnN;
      logic                   writeEnN;
      logic [ASBP_ADDR_W-1:0] wordAddress;
      logic [ASBP_DATA_W-1:0] byteDataOut;
      logic                   byteDataOe;
   } asbp_pins_t;

   typedef enum logic [2:0] {
      ASBP_IDLE  = 3'b000,
      ASBP_SETUP = 3'b001,
      ASBP_READ  = 3'b011,
      ASBP_WRITE = 3'b010,
      ASBP_RECOV = 3'b110
   } asbp_state_t;
endpackage

// *** logic/asbp_sync.sv ***
// Two-flop synchroniser for the returning data pins
`timescale 1ns/1ps
module asbp_sync
   import asbp_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   clkEn,
   input  wire logic [ASBP_DATA_W-1:0] din,
   output logic      [ASBP_DATA_W-1:0] dout
);
   logic [ASBP_DATA_W-1:0] meta_q;
   logic [ASBP_DATA_W-1:0] meta_d;
   logic [ASBP_DATA_W-1:0] sync_q;
   logic [ASBP_DATA_W-1:0] sync_d;

   always_comb begin
      meta_d = clkEn ? din : meta_q;
      sync_d = clkEn ? meta_q : sync_q;
   end

   always_ff @(posedge clk) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
   end

   assign dout = sync_q;
endmodule // asbp_sync

// *** dv/asbp_sram_model.sv ***
// Behavioural byte-wide static memory on the host pins
`timescale 1ns/1ps
module asbp_sram_model
   import asbp_pkg::*;
(
   input  wire logic                   clk,
   input  wire asbp_pins_t             pins,
   output logic      [ASBP_DATA_W-1:0] byteDataIn
);
   logic [ASBP_DATA_W-1:0] mem [0:(1<<ASBP_ADDR_W)-1];
   logic [ASBP_DATA_W-1:0] lastQ = 8'h00;
   logic                   drive;
   assign drive = !pins.chipSelN && !pins.outEnN && pins.writeEnN;
   assign byteDataIn = drive ? mem[pins.wordAddress]
      : pins.byteDataOe ? pins.byteDataOut : ~lastQ;
   always @(posedge clk) begin
      lastQ <= byteDataIn;
      if (!pins.chipSelN && !pins.writeEnN) begin
         mem[pins.wordAddress] <= pins.byteDataOut;
      end
   end
endmodule // asbp_sram_model

// *** dv/asbp_host_props.sv ***
// Pin protocol checker for the host controller
`timescale 1ns/1ps
module asbp_host_props
   import asbp_pkg::*;
(
   input wire logic                   clk,
   input wire logic                   reset,
   input wire logic                   clkEn,
   input wire logic                   reqValid,
   input wire logic                   reqReady,
   input wire logic                   rdValid,
   input wire logic                   chipSelN,
   input wire logic                   outEnN,
   input wire logic                   writeEnN,
   input wire logic [ASBP_ADDR_W-1:0] wordAddress,
   input wire logic [ASBP_DATA_W-1:0] byteDataOut,
   input wire logic                   byteDataOe
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_no_contention: assert property (byteDataOe |-> outEnN)
      else $error("host drives during read");
   a_read_we_high: assert property (!outEnN |-> writeEnN)
      else $error("write enable low in read");
   a_write_selected: assert property (!writeEnN |-> !chipSelN)
      else $error("write without select");
   a_deselect_idle: assert property (chipSelN |-> writeEnN && outEnN)
      else $error("strobe while deselected");
   a_write_setup: assert property (!writeEnN |-> $stable(wordAddress)
      && $stable(byteDataOut) && byteDataOe) else $error("write setup broken");
   a_write_hold: assert property ($rose(writeEnN) |-> $stable(wordAddress)
      && $stable(byteDataOut) && byteDataOe) else $error("write hold broken");
   a_write_pulse: assert property ($fell(writeEnN) |=> writeEnN && chipSelN)
      else $error("write pulse length");
   a_read_answer: assert property ($fell(outEnN) |-> ##3 rdValid)
      else $error("read answer late");
   a_addr_first: assert property ($fell(chipSelN) |-> $stable(wordAddress))
      else $error("address moved at select");
   a_busy_refuse: assert property (clkEn && reqValid && reqReady |=> !reqReady [*3])
      else $error("ready while busy");
endmodule // asbp_host_props
bind asbp_host asbp_host_props u_asbp_host_props (.clk, .reset, .clkEn, .reqValid, .reqReady,
   .rdValid, .chipSelN, .outEnN, .writeEnN, .wordAddress, .byteDataOut, .byteDataOe);

// *** dv/tb_top.sv ***
// Self-checking bench for the host controller
`timescale 1ns/1ps
module tb_top
   import asbp_pkg::*;
;
   logic                   clk = 1'b0;
   logic                   reset = 1'b1;
   logic                   clkEn = 1'b1;
   logic                   reqValid = 1'b0;
   asbp_req_t              req = '0;
   logic                   reqReady, rdValid, chipSelN, outEnN, writeEnN, byteDataOe;
   logic [ASBP_DATA_W-1:0] rdData, byteDataOut, byteDataIn, q;
   logic [ASBP_ADDR_W-1:0] wordAddress;
   asbp_pins_t             pins;
   int                     fails = 0;
   int                     n_checks = 0;
   int                     cyc = 0;
   assign pins = {chipSelN, outEnN, writeEnN, wordAddress, byteDataOut, byteDataOe};
   asbp_host u_asbp_host (.clk(clk), .reset(reset), .clkEn(clkEn), .reqValid(reqValid),
      .req(req), .reqReady(reqReady), .rdValid(rdValid), .rdData(rdData),
      .chipSelN(chipSelN), .outEnN(outEnN), .writeEnN(writeEnN),
      .wordAddress(wordAddress), .byteDataOut(byteDataOut), .byteDataOe(byteDataOe),
      .byteDataIn(byteDataIn));
   asbp_sram_model u_asbp_sram_model (.clk(clk), .pins(pins), .byteDataIn(byteDataIn));
   initial forever #12.5 clk = ~clk;
   task automatic test_done();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic access(input logic w, input logic [18:0] a, input logic [7:0] d);
      @(posedge clk);
      reqValid <= 1'b1;
      req <= '{w, a, d};
      @(negedge clk);
      while (reqReady !== 1'b1) @(negedge clk);
      @(posedge clk);
      reqValid <= 1'b0;
      if (!w) begin
         @(negedge clk);
         while (rdValid !== 1'b1) @(negedge clk);
         q = rdData;
      end
   endtask
   task automatic t_corners();
      access(1'b1, 19'h00000, 8'ha5);
      access(1'b1, 19'h7ffff, 8'h5a);
      access(1'b0, 19'h00000, 8'h00);
      chk("low end", 8'ha5, q);
      access(1'b0, 19'h7ffff, 8'h00);
      chk("high end", 8'h5a, q);
   endtask
   task automatic t_overwrite();
      access(1'b1, 19'h00123, 8'h3c);
      access(1'b1, 19'h00123, 8'hc3);
      access(1'b0, 19'h00123, 8'h00);
      chk("overwrite", 8'hc3, q);
   endtask
   task automatic t_sweep();
      for (int i = 0; i < 4; i++) access(1'b1, 19'h1 << (i * 6), 8'(8'h11 * (i + 1)));
      for (int i = 0; i < 4; i++) begin
         access(1'b0, 19'h1 << (i * 6), 8'h00);
         chk("sweep", 8'(8'h11 * (i + 1)), q);
      end
   endtask
   task automatic t_freeze();
      @(posedge clk);
      clkEn <= 1'b0;
      reqValid <= 1'b1;
      req <= '{1'b0, 19'h00123, 8'h00};
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("frozen", 8'h03, {6'h00, reqReady, chipSelN});
      @(posedge clk);
      clkEn <= 1'b1;
      reqValid <= 1'b0;
      access(1'b0, 19'h00123, 8'h00);
      chk("thawed", 8'hc3, q);
   endtask
   task automatic t_reset();
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      chk("ready in reset", 8'h00, {7'h00, reqReady});
      access(1'b0, 19'h00000, 8'h00);
      chk("kept", 8'ha5, q);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         test_done();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      t_corners();
      t_overwrite();
      t_sweep();
      t_freeze();
      t_reset();
      test_done();
   end
endmodule // tb_top
